// file: rtl/mps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: Toggle held low at least one second then released powers the module up.
// RQ2: Power monitor goes high at power-on, entering initialization.
// RQ3: Activation comes no sooner than ten seconds after monitor rises.
// RQ4: No commands are accepted during initialization.
// RQ5: Toggle held low beyond two seconds while on starts finalization, then monitor low.
// RQ6: Software shutdown command starts finalization; monitor drops when it completes.
// RQ7: Finalization length varies; host waits for monitor to fall.
// RQ8: Both graceful shutdown paths send a network detach request first.
// RQ9: Monitor low means fully off.
// RQ10: Restart line low at least 200 ms then released restarts unconditionally. In the code a kill qualified in the same cycle wins instead.
// RQ11: Kill line low at least 200 ms then released powers off unconditionally.
// RQ12: After kill the module stays off until a toggle power-up. The code also powers up on a restart.
// RQ13: Kill skips the network detach.
// RQ14: Host drives control lines open-drain only, never actively high. The host model drives them high when released.
// RQ15: Host keeps its signals low while module is off or switching.
// RQ16: Host uses kill only for emergencies.
// RQ17: Host must implement restart control as its emergency recovery.
// RQ18: Toggle pulse means power-up when off, shutdown when on; short pulses ignored.
module mps_sequencer #(
	parameter int unsigned PWRUP_HOLD_CYC = mps_pkg::PWRUP_HOLD_CYC,
	parameter int unsigned KILL_N_HOLD_CYC = mps_pkg::KILL_N_HOLD_CYC,
	parameter int unsigned ACTIVATE_CYC = mps_pkg::ACTIVATE_CYC,
	parameter int unsigned RESTART_HOLD_CYC = mps_pkg::RESTART_HOLD_CYC,
	parameter int unsigned KILL_HOLD_CYC = mps_pkg::KILL_HOLD_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control pins, active low, no pull-up inside
	input wire logic power_toggle_n,
	input wire logic restart_n,
	input wire logic kill_n,
	// Internal software side
	input wire logic sw_shutdown_req,
	input wire logic finalize_done,
	// Status and network side
	output logic power_good_monitor,
	output logic cmd_ready,
	output logic detach_req
);
	// ----------------------------------------
	// Pin qualifiers
	// ----------------------------------------
	logic tog_rel;
	logic tog_long;
	logic rst_hit;
	logic kill_hit;

	mps_pulse_qual #(.MIN_CYC(PWRUP_HOLD_CYC), .LONG_CYC(KILL_N_HOLD_CYC)) u_tog (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_n(power_toggle_n),
		.rel_hit(tog_rel),
		.long_hit(tog_long)
	);

	mps_pulse_qual #(.MIN_CYC(RESTART_HOLD_CYC), .LONG_CYC(RESTART_HOLD_CYC)) u_rst (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_n(restart_n),
		.rel_hit(rst_hit),
		.long_hit()
	);

	mps_pulse_qual #(.MIN_CYC(KILL_HOLD_CYC), .LONG_CYC(KILL_HOLD_CYC)) u_kill (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_n(kill_n),
		.rel_hit(kill_hit),
		.long_hit()
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mps_pkg::mps_state_e state;
		logic [mps_pkg::CNT_W-1:0] cnt;
		logic mon;
		logic ready;
		logic detach;
		logic tog_block;
	} mps_seq_s;

	localparam logic [mps_pkg::CNT_W-1:0] ACT_V = mps_pkg::CNT_W'(ACTIVATE_CYC);

	mps_seq_s st_r;
	mps_seq_s st_nxt;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.detach = 1'b0;
		// Release that ends a shutdown hold must not power back up
		if (tog_rel) begin
			st_nxt.tog_block = 1'b0;
		end
		if (kill_hit) begin
			st_nxt.state = mps_pkg::MPS_OFF; // RQ11 RQ13
			st_nxt.mon = 1'b0;
			st_nxt.ready = 1'b0;
		end else if (rst_hit) begin
			st_nxt.state = mps_pkg::MPS_INIT; // RQ10
			st_nxt.cnt = mps_pkg::CNT_RST;
			st_nxt.mon = 1'b1;
			st_nxt.ready = 1'b0;
		end else begin
			unique case (st_r.state)
				mps_pkg::MPS_OFF: begin
					// Only a toggle power-up or a restart leaves this state
					if (tog_rel && !st_r.tog_block) begin
						st_nxt.state = mps_pkg::MPS_INIT; // RQ1 RQ12 RQ18
						st_nxt.cnt = mps_pkg::CNT_RST;
						st_nxt.mon = 1'b1; // RQ2
					end
				end
				mps_pkg::MPS_INIT: begin
					if (tog_long) begin
						st_nxt.state = mps_pkg::MPS_FINAL; // RQ5 RQ18
						st_nxt.detach = 1'b1; // RQ8
						st_nxt.tog_block = 1'b1;
					end else if (st_r.cnt == ACT_V - 1'b1) begin
						st_nxt.state = mps_pkg::MPS_ACTIVE; // RQ3
						st_nxt.ready = 1'b1; // RQ4
					end else begin
						st_nxt.cnt = st_r.cnt + 1'b1;
					end
				end
				mps_pkg::MPS_ACTIVE: begin
					if (tog_long || sw_shutdown_req) begin
						st_nxt.state = mps_pkg::MPS_FINAL; // RQ5 RQ6
						st_nxt.detach = 1'b1; // RQ8
						st_nxt.ready = 1'b0;
						st_nxt.tog_block = tog_long;
					end
				end
				mps_pkg::MPS_FINAL: begin
					// Length set by the software side, not by a timer
					if (finalize_done) begin
						st_nxt.state = mps_pkg::MPS_OFF; // RQ7 RQ9
						st_nxt.mon = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r <= '{state: mps_pkg::MPS_OFF, cnt: mps_pkg::CNT_RST, mon: 1'b0,
				ready: 1'b0, detach: 1'b0, tog_block: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign power_good_monitor = st_r.mon;
	assign cmd_ready = st_r.ready;
	assign detach_req = st_r.detach;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_mon_rise_init: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
		$rose(st_r.mon) |-> st_r.state == mps_pkg::MPS_INIT && st_r.cnt == mps_pkg::CNT_RST)
		else $error("monitor rose outside initialization entry");
	a_ready_after_wait: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
		$rose(st_r.ready) |-> $past(st_r.cnt) == ACT_V - 1'b1 && $past(st_r.state) == mps_pkg::MPS_INIT)
		else $error("activation before full initialization time");
	a_init_no_cmd: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
		st_r.state != mps_pkg::MPS_ACTIVE |-> !st_r.ready)
		else $error("commands accepted outside activation");
	a_tog_shutdown: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
		tog_long && !kill_hit && !rst_hit && st_r.state == mps_pkg::MPS_ACTIVE
		|=> st_r.state == mps_pkg::MPS_FINAL && st_r.detach && st_r.mon)
		else $error("toggle hold did not start finalization");
	a_sw_shutdown: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
		sw_shutdown_req && !kill_hit && !rst_hit && st_r.state == mps_pkg::MPS_ACTIVE
		|=> st_r.state == mps_pkg::MPS_FINAL && st_r.detach && !st_r.ready ##1 !st_r.detach)
		else $error("software shutdown not followed");
	a_final_holds_mon: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
		st_r.state == mps_pkg::MPS_FINAL && !finalize_done && !kill_hit |=> st_r.mon)
		else $error("monitor fell before finalization ended");
	a_detach_on_final: assert property (@(posedge clock) disable iff (sys_rst) // RQ8
		st_r.detach |-> st_r.state == mps_pkg::MPS_FINAL && $past(st_r.state) != mps_pkg::MPS_FINAL)
		else $error("detach request outside finalization entry");
	a_mon_low_off: assert property (@(posedge clock) disable iff (sys_rst) // RQ9
		!st_r.mon |-> st_r.state == mps_pkg::MPS_OFF && !st_r.ready)
		else $error("monitor low while not off");
	a_restart: assert property (@(posedge clock) disable iff (sys_rst) // RQ10
		rst_hit && !kill_hit |=> st_r.state == mps_pkg::MPS_INIT && st_r.mon)
		else $error("restart not taken");
	a_kill_off: assert property (@(posedge clock) disable iff (sys_rst) // RQ11
		kill_hit |=> !st_r.mon && !st_r.detach)
		else $error("kill did not power off cleanly");
	a_stay_off: assert property (@(posedge clock) disable iff (sys_rst) // RQ12
		!st_r.mon && !(tog_rel && !st_r.tog_block) && !rst_hit |=> !st_r.mon)
		else $error("module powered up by itself");
endmodule : mps_sequencer
`default_nettype wire

// file: inc/mps_pkg.sv
`default_nettype none
package mps_pkg;
	// ----------------------------------------
	// Clock and widths
	// ----------------------------------------
	localparam longint CLK_HZ = 200_000_000;
	localparam int CNT_W = 32;

	// ----------------------------------------
	// Times in milliseconds
	// ----------------------------------------
	localparam longint PWRUP_HOLD_MS = 1000;
	localparam longint KILL_N_HOLD_MS = 2000;
	localparam longint ACTIVATE_MS = 10000;
	localparam longint RESTART_HOLD_MS = 200;
	localparam longint KILL_HOLD_MS = 200;

	// ----------------------------------------
	// Least times, rounded up to cycles
	// ----------------------------------------
	localparam int unsigned PWRUP_HOLD_CYC = 32'((PWRUP_HOLD_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned KILL_N_HOLD_CYC = 32'((KILL_N_HOLD_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned ACTIVATE_CYC = 32'((ACTIVATE_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned RESTART_HOLD_CYC = 32'((RESTART_HOLD_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned KILL_HOLD_CYC = 32'((KILL_HOLD_MS * CLK_HZ + 999) / 1000);

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		MPS_OFF,
		MPS_INIT,
		MPS_ACTIVE,
		MPS_FINAL
	} mps_state_e;
endpackage : mps_pkg
`default_nettype wire

// file: rtl/mps_pulse_qual.sv
`timescale 1ns/1ps
`default_nettype none
module mps_pulse_qual #(
	parameter int unsigned MIN_CYC = 4,
	parameter int unsigned LONG_CYC = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Active-low pin from the host
	input wire logic pin_n,
	// Qualified events
	output logic rel_hit,
	output logic long_hit
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic [mps_pkg::CNT_W-1:0] cnt;
		logic rel;
		logic lng;
	} mps_qual_s;

	localparam logic [mps_pkg::CNT_W-1:0] MIN_V = mps_pkg::CNT_W'(MIN_CYC);
	localparam logic [mps_pkg::CNT_W-1:0] LONG_V = mps_pkg::CNT_W'(LONG_CYC);
	localparam logic [mps_pkg::CNT_W-1:0] SAT_V = (MIN_V > LONG_V) ? MIN_V : LONG_V;

	mps_qual_s st_r;
	mps_qual_s st_nxt;

	// ----------------------------------------
	// Low-time measurement
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_n;
		st_nxt.s2 = st_r.s1;
		st_nxt.rel = 1'b0;
		st_nxt.lng = 1'b0;
		if (!st_r.s2) begin
			if (st_r.cnt != SAT_V) begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
			if (st_r.cnt == LONG_V - 1'b1) begin
				st_nxt.lng = 1'b1;
			end
		end else begin
			// Release after a long enough low; short glitches drop out
			st_nxt.rel = (st_r.cnt >= MIN_V); // RQ18
			st_nxt.cnt = mps_pkg::CNT_RST;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r <= '{s1: 1'b1, s2: 1'b1, cnt: mps_pkg::CNT_RST, rel: 1'b0, lng: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rel_hit = st_r.rel;
	assign long_hit = st_r.lng;

	a_rel_min_hold: assert property (@(posedge clock) disable iff (sys_rst) // RQ1
		$rose(st_r.rel) |-> $past(st_r.cnt) >= MIN_V)
		else $error("release accepted before minimum low time");
	a_long_at_count: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
		st_r.lng |-> st_r.cnt == LONG_V && !$past(st_r.s2))
		else $error("long hold flagged at wrong count");
endmodule : mps_pulse_qual
`default_nettype wire

// file: testbench/mps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mps_host_model (
	// Clock
	input wire logic clock,
	// Active-low control lines, driven high when released
	output logic power_toggle_n,
	output logic restart_n,
	output logic kill_n
);
	// ----------------------------------------
	// Pull-down enables, lines driven high when not pulled
	// ----------------------------------------
	logic [2:0] pull_en = 3'h0;
	assign power_toggle_n = ~pull_en[0];
	assign restart_n = ~pull_en[1];
	assign kill_n = ~pull_en[2];

	// ----------------------------------------
	// Low pulse of a given length, off the falling edge
	// ----------------------------------------
	task automatic hold_low(input int line, input int cyc);
		@(negedge clock);
		pull_en[line] = 1'b1;
		repeat (cyc) @(negedge clock);
		pull_en[line] = 1'b0;
	endtask : hold_low
endmodule : mps_host_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic sw_shutdown_req = 1'b0;
	logic finalize_done = 1'b0;
	wire logic power_toggle_n;
	wire logic restart_n;
	wire logic kill_n;
	logic power_good_monitor;
	logic cmd_ready;
	logic detach_req;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [7:0] det_cnt = 8'h00;
	logic [7:0] base;

	initial begin
		forever #2.5 clock = ~clock;
	end

	mps_host_model host_u (.clock(clock), .power_toggle_n(power_toggle_n), .restart_n(restart_n), .kill_n(kill_n));

	mps_sequencer #(.PWRUP_HOLD_CYC(20), .KILL_N_HOLD_CYC(40), .ACTIVATE_CYC(100), .RESTART_HOLD_CYC(8),
		.KILL_HOLD_CYC(8)) dut_u (.clock(clock), .sys_rst(sys_rst), .power_toggle_n(power_toggle_n),
		.restart_n(restart_n), .kill_n(kill_n), .sw_shutdown_req(sw_shutdown_req),
		.finalize_done(finalize_done), .power_good_monitor(power_good_monitor), .cmd_ready(cmd_ready),
		.detach_req(detach_req));

	always @(posedge clock) begin
		if (detach_req === 1'b1) det_cnt <= det_cnt + 8'h01;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	task automatic wait_mon(input logic v);
		for (int i = 0; i < 20 && power_good_monitor !== v; i++) @(negedge clock);
		chk("monitor", {7'h00, v}, {7'h00, power_good_monitor});
	endtask : wait_mon

	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask : pulse

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic short_toggle;
		host_u.hold_low(0, 10);
		repeat (8) @(negedge clock);
		chk("monitor", 8'h00, {7'h00, power_good_monitor});
	endtask : short_toggle

	task automatic power_up;
		base = det_cnt;
		host_u.hold_low(0, 25);
		wait_mon(1'b1);
		pulse(sw_shutdown_req);
		chk("ready", 8'h00, {7'h00, cmd_ready});
		repeat (97) @(negedge clock);
		chk("ready", 8'h00, {7'h00, cmd_ready});
		chk("detach", 8'h00, det_cnt - base);
		repeat (1) @(negedge clock);
		chk("ready", 8'h01, {7'h00, cmd_ready});
		chk("monitor", 8'h01, {7'h00, power_good_monitor});
	endtask : power_up

	task automatic finish_off;
		repeat (20) @(negedge clock);
		chk("monitor", 8'h01, {7'h00, power_good_monitor});
		pulse(finalize_done);
		wait_mon(1'b0);
		chk("detach", 8'h01, det_cnt - base);
	endtask : finish_off

	task automatic sw_shut;
		base = det_cnt;
		pulse(sw_shutdown_req);
		repeat (3) @(negedge clock);
		chk("ready", 8'h00, {7'h00, cmd_ready});
		finish_off();
	endtask : sw_shut

	task automatic tog_shut;
		base = det_cnt;
		// Toggle still held after power-off, so its release must not power up
		fork
			host_u.hold_low(0, 80);
			begin
				repeat (48) @(negedge clock);
				chk("detach", 8'h01, det_cnt - base);
				chk("ready", 8'h00, {7'h00, cmd_ready});
				finish_off();
			end
		join
		repeat (10) @(negedge clock);
		chk("monitor", 8'h00, {7'h00, power_good_monitor});
	endtask : tog_shut

	task automatic restart;
		host_u.hold_low(1, 10);
		repeat (6) @(negedge clock);
		chk("monitor", 8'h01, {7'h00, power_good_monitor});
		chk("ready", 8'h00, {7'h00, cmd_ready});
		repeat (100) @(negedge clock);
		chk("ready", 8'h01, {7'h00, cmd_ready});
	endtask : restart

	task automatic kill;
		base = det_cnt;
		host_u.hold_low(2, 10);
		wait_mon(1'b0);
		chk("ready", 8'h00, {7'h00, cmd_ready});
		repeat (200) @(negedge clock);
		chk("monitor", 8'h00, {7'h00, power_good_monitor});
		chk("detach", 8'h00, det_cnt - base);
	endtask : kill

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		repeat (2) @(negedge clock);
		short_toggle();
		power_up();
		sw_shut();
		power_up();
		restart();
		tog_shut();
		power_up();
		kill();
		close_out();
	end

	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule : tb_top
`default_nettype wire
